//--- rtl/osw_params.svh
// Register offsets, reset values, field positions and command codes of the switch register bank
`ifndef OSW_PARAMS_SVH
`define OSW_PARAMS_SVH

`define OSW_ADDR_SWITCH   7'h01
`define OSW_ADDR_CFG      7'h02
`define OSW_ADDR_STATUS   7'h03
`define OSW_ADDR_BURST    7'h05
`define OSW_ADDR_KEY      7'h0B

`define OSW_SWITCH_RST    8'h00
`define OSW_CFG_RST       8'h06
`define OSW_STATUS_RST    8'h00
`define OSW_BURST_RST     8'h00
`define OSW_KEY_RST       8'h00

`define OSW_CFG_WMASK     8'h07
`define OSW_BURST_WMASK   8'h01

`define OSW_CRC_EN_BIT    0
`define OSW_CNT_EN_BIT    1
`define OSW_ADDR_EN_BIT   2
`define OSW_CRC_FLAG_BIT  0
`define OSW_CNT_FLAG_BIT  1
`define OSW_ADDR_FLAG_BIT 2
`define OSW_BURST_BIT     0
`define OSW_READ_BIT      15

`define OSW_CLEAR_CMD     16'h6CA9
`define OSW_KEY_FIRST     8'hA3
`define OSW_KEY_SECOND    8'h05
`define OSW_CRC_POLY      8'h07
`define OSW_CRC_SEED      8'h00

`endif

//--- rtl/osw_pkg.sv
// Types shared by the link receiver and the register bank
package osw_pkg;

  // Byte position inside one command word
  typedef enum logic [1:0] {
    OSW_ST_HI,
    OSW_ST_LO,
    OSW_ST_CRC
  } osw_byte_t;

  // Link side to core: byte event toggle, byte, leftover bit count
  typedef struct packed {
    logic       tgl;
    logic [7:0] data;
    logic [2:0] rem;
  } osw_link_t;

  // One decoded command word
  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } osw_cmd_t;

endpackage

//--- rtl/osw_link.sv
// Serial receiver and response shifter running on the serial clock
module osw_link (
  // Serial pins
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdi,
  output logic                   sdo,
  output logic                   sdo_oe,
  // Core side
  input  wire logic              nrst,
  input  wire logic [15:0]       resp,
  output osw_pkg::osw_link_t     link
);

  logic       in_frame_r;
  logic [3:0] pos_r;
  logic [3:0] pos_cur;
  logic [3:0] pos_nxt;
  logic [6:0] shift_r;
  logic [7:0] data_r;
  logic       tgl_r;
  logic       frame_rst_n;
  logic       byte_done;

  // The serial clock stops between frames, so chip select clears the frame flag
  assign frame_rst_n = nrst & ~cs_n;
  assign pos_cur     = in_frame_r ? pos_r : 4'h0;
  assign pos_nxt     = pos_cur + 4'h1;
  assign byte_done   = (pos_cur[2:0] == 3'h7);
  assign sdo         = resp[~pos_cur];
  assign sdo_oe      = ~cs_n;

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
    end
  end

  // Position and shift survive chip select so the core can read the leftover count
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      pos_r   <= 4'h0;
      shift_r <= 7'h00;
    end else begin
      pos_r   <= pos_nxt;
      shift_r <= {shift_r[5:0], sdi};
    end
  end

  // Byte held stable until the next one, at least eight serial clocks later
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      data_r <= 8'h00;
      tgl_r  <= 1'b0;
    end else if (byte_done) begin
      data_r <= {shift_r, sdi};
      tgl_r  <= ~tgl_r;
    end
  end

  // One driver for the whole carrier
  assign link = {tgl_r, data_r, pos_r[2:0]};

endmodule

//--- rtl/osw_regs.sv
// Register bank of the eight-switch serial device with frame error checking
`include "osw_params.svh"

module osw_regs (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // Switch controls
  output logic [7:0]      switch_close
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ********************************
  // Link crossing
  // ********************************
  osw_pkg::osw_link_t link;
  logic [15:0]        resp_r;
  logic               cs_s1_r;
  logic               cs_s2_r;
  logic               cs_d_r;
  logic               fe_r;
  logic               t_s1_r;
  logic               t_s2_r;
  logic               t_d_r;
  logic               byte_ev;
  logic               frame_end;

  osw_link i_osw_link (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .sdi    (sdi),
    .sdo    (sdo),
    .sdo_oe (sdo_oe),
    .nrst   (nrst),
    .resp   (resp_r),
    .link   (link)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r  <= 1'b1;
      fe_r    <= 1'b0;
      t_s1_r  <= 1'b0;
      t_s2_r  <= 1'b0;
      t_d_r   <= 1'b0;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r  <= cs_s2_r;
      fe_r    <= frame_end;
      t_s1_r  <= link.tgl;
      t_s2_r  <= t_s1_r;
      t_d_r   <= t_s2_r;
    end
  end

  // Frame end is taken a cycle late so the last byte is always handled first
  assign frame_end = cs_s2_r & ~cs_d_r;
  assign byte_ev   = t_s2_r ^ t_d_r;

  // ********************************
  // Registers and word assembly
  // ********************************
  logic [7:0]          sw_r;
  logic [7:0]          cfg_r;
  logic [7:0]          flg_r;
  logic [7:0]          bst_r;
  logic [7:0]          key_r;
  logic                armed_r;
  logic                stage_v_r;
  logic [7:0]          stage_d_r;
  logic [7:0]          hi_r;
  logic [7:0]          lo_r;
  logic [1:0]          words_r;
  osw_pkg::osw_byte_t  idx_r;
  osw_pkg::osw_byte_t  idx_nxt;
  logic                crc_en;
  logic                cnt_en;
  logic                addr_en;
  logic                burst;
  logic                word_done;
  logic                accept;
  osw_pkg::osw_cmd_t   cmd;
  logic [7:0]          crc_calc;
  logic                crc_bad;
  logic                is_clear;
  logic                mapped;
  logic                addr_bad;
  logic                do_wr;
  logic                clr;
  logic                soft_rst;
  logic                cnt_ok;
  logic                commit;
  logic [7:0]          rdata;
  logic [7:0]          flg_set;

  function automatic logic [7:0] osw_crc8(input logic [15:0] d);
    logic [7:0] c;
    c = `OSW_CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `OSW_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  assign crc_en  = cfg_r[`OSW_CRC_EN_BIT];
  assign cnt_en  = cfg_r[`OSW_CNT_EN_BIT];
  assign addr_en = cfg_r[`OSW_ADDR_EN_BIT];
  assign burst   = bst_r[`OSW_BURST_BIT];
  // CRC lengthens each word to three bytes
  assign word_done = byte_ev && ((idx_r == osw_pkg::OSW_ST_LO && !crc_en) ||
                                 idx_r == osw_pkg::OSW_ST_CRC);
  // later words of a frame act only in burst
  assign accept    = word_done && (burst || words_r == 2'h0);
  assign cmd       = {hi_r, (idx_r == osw_pkg::OSW_ST_LO) ? link.data : lo_r};
  assign crc_calc  = osw_crc8(cmd);
  assign crc_bad   = crc_en && (crc_calc != link.data);
  assign is_clear  = (cmd == `OSW_CLEAR_CMD);
  assign mapped    = (cmd.addr == `OSW_ADDR_SWITCH) || (cmd.addr == `OSW_ADDR_CFG) ||
                     (cmd.addr == `OSW_ADDR_STATUS) || (cmd.addr == `OSW_ADDR_BURST) ||
                     (cmd.addr == `OSW_ADDR_KEY);
  // missing register or write to read-only status
  assign addr_bad  = !is_clear && (!mapped || (!cmd.rd && cmd.addr == `OSW_ADDR_STATUS));
  assign do_wr     = accept && !crc_bad && !cmd.rd && !addr_bad;
  assign clr       = accept && !crc_bad && is_clear;
  assign soft_rst  = do_wr && cmd.addr == `OSW_ADDR_KEY && cmd.data == `OSW_KEY_SECOND &&
                     armed_r;
  assign cnt_ok = (link.rem == 3'h0) && (idx_r == osw_pkg::OSW_ST_HI) &&
                  (words_r != 2'h0) && (burst || words_r == 2'h1);
  // staged switch data commits at frame end unless the enabled count check fails
  assign commit = fe_r && stage_v_r && !(cnt_en && !cnt_ok);

  assign rdata = (cmd.addr == `OSW_ADDR_SWITCH) ? sw_r  :
                 (cmd.addr == `OSW_ADDR_CFG)    ? cfg_r :
                 (cmd.addr == `OSW_ADDR_STATUS) ? flg_r :
                 (cmd.addr == `OSW_ADDR_BURST)  ? bst_r :
                 (cmd.addr == `OSW_ADDR_KEY)    ? key_r : 8'h00;

  assign flg_set = {5'h00,
                    accept && !crc_bad && addr_en && addr_bad,
                    fe_r && cnt_en && !cnt_ok,
                    accept && crc_bad};

  always_comb begin
    idx_nxt = idx_r;
    if (fe_r) begin
      idx_nxt = osw_pkg::OSW_ST_HI;
    end else if (byte_ev) begin
      case (idx_r)
        osw_pkg::OSW_ST_HI:  idx_nxt = osw_pkg::OSW_ST_LO;
        osw_pkg::OSW_ST_LO:  idx_nxt = crc_en ? osw_pkg::OSW_ST_CRC : osw_pkg::OSW_ST_HI;
        osw_pkg::OSW_ST_CRC: idx_nxt = osw_pkg::OSW_ST_HI;
        default:             idx_nxt = osw_pkg::OSW_ST_HI;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idx_r   <= osw_pkg::OSW_ST_HI;
      hi_r    <= 8'h00;
      lo_r    <= 8'h00;
      words_r <= 2'h0;
    end else begin
      idx_r <= idx_nxt;
      if (byte_ev && idx_r == osw_pkg::OSW_ST_HI) begin
        hi_r <= link.data;
      end
      if (byte_ev && idx_r == osw_pkg::OSW_ST_LO) begin
        lo_r <= link.data;
      end
      if (fe_r) begin
        words_r <= 2'h0;
      end else if (word_done && words_r != 2'h2) begin
        words_r <= words_r + 2'h1;
      end
    end
  end

  // Response goes out on the next command slot
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      resp_r <= 16'h0000;
    end else if (accept) begin
      resp_r <= {cmd[15:8], rdata};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sw_r      <= `OSW_SWITCH_RST;
      stage_v_r <= 1'b0;
      stage_d_r <= `OSW_SWITCH_RST;
    end else if (soft_rst) begin
      sw_r      <= `OSW_SWITCH_RST;
      stage_v_r <= 1'b0;
    end else begin
      if (commit) begin
        sw_r <= stage_d_r;
      end
      if (do_wr && cmd.addr == `OSW_ADDR_SWITCH) begin
        stage_v_r <= 1'b1;
        stage_d_r <= cmd.data;
      end else if (fe_r) begin
        stage_v_r <= 1'b0;
      end
    end
  end

  assign switch_close = sw_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_r   <= `OSW_CFG_RST;
      bst_r   <= `OSW_BURST_RST;
      key_r   <= `OSW_KEY_RST;
      armed_r <= 1'b0;
    end else if (soft_rst) begin
      cfg_r   <= `OSW_CFG_RST;
      bst_r   <= `OSW_BURST_RST;
      key_r   <= `OSW_KEY_RST;
      armed_r <= 1'b0;
    end else if (accept) begin
      if (do_wr && cmd.addr == `OSW_ADDR_CFG) begin
        cfg_r <= cmd.data & `OSW_CFG_WMASK;
      end
      if (do_wr && cmd.addr == `OSW_ADDR_BURST) begin
        bst_r <= cmd.data & `OSW_BURST_WMASK;
      end
      if (do_wr && cmd.addr == `OSW_ADDR_KEY) begin
        key_r <= cmd.data;
      end
      armed_r <= do_wr && cmd.addr == `OSW_ADDR_KEY && cmd.data == `OSW_KEY_FIRST;
    end
  end

  // a new error in the clearing cycle survives
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flg_r <= `OSW_STATUS_RST;
    end else if (soft_rst) begin
      flg_r <= `OSW_STATUS_RST;
    end else begin
      flg_r <= (clr ? `OSW_STATUS_RST : flg_r) | flg_set;
    end
  end

  // ********************************
  // Checks
  // ********************************
  property p_switch_commit;
    commit && !soft_rst |=> switch_close == $past(stage_d_r);
  endproperty
  a_switch_commit: assert property (p_switch_commit) else $error("switch commit lost");
  property p_switch_soft;
    soft_rst |=> sw_r == 8'h00 && !stage_v_r;
  endproperty
  a_switch_soft: assert property (p_switch_soft) else $error("switch not opened");
  property p_cfg_soft;
    soft_rst |=> cfg_r == 8'h06 && bst_r == 8'h00;
  endproperty
  a_cfg_soft: assert property (p_cfg_soft) else $error("config not default");
  property p_addr_gate;
    $rose(flg_r[2]) |-> $past(addr_en) && $past(accept);
  endproperty
  a_addr_gate: assert property (p_addr_gate) else $error("address flag ungated");
  property p_cnt_err;
    fe_r && cnt_en && !cnt_ok && !soft_rst |=> flg_r[1];
  endproperty
  a_cnt_err: assert property (p_cnt_err) else $error("count error missed");
  property p_cnt_single;
    fe_r && cnt_en && !burst && words_r != 2'h1 |=> flg_r[1];
  endproperty
  a_cnt_single: assert property (p_cnt_single) else $error("bad single word count");
  property p_burst_many;
    fe_r && cnt_en && burst && (link.rem != 3'h0 || idx_r != osw_pkg::OSW_ST_HI) |=> flg_r[1];
  endproperty
  a_burst_many: assert property (p_burst_many) else $error("burst count error missed");
  property p_crc_block;
    accept && crc_bad && !fe_r |-> !do_wr ##1 flg_r[0];
  endproperty
  a_crc_block: assert property (p_crc_block) else $error("bad CRC acted");
  property p_cfg_resv;
    cfg_r[7:3] == 5'h00 && bst_r[7:1] == 7'h00;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv) else $error("reserved bits set");
  property p_clear;
    clr && !fe_r |=> flg_r == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear frame failed");
  property p_addr_flag;
    accept && !crc_bad && addr_en && !mapped && !is_clear && !soft_rst |=> flg_r[2];
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("address flag missed");
  property p_soft_seq;
    soft_rst |-> armed_r && $past(key_r) == 8'hA3;
  endproperty
  a_soft_seq: assert property (p_soft_seq) else $error("soft reset unarmed");
  property p_sw_cause;
    $changed(sw_r) |-> $past(commit) || $past(soft_rst);
  endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("switch changed early");

endmodule

//--- tb/osw_host.sv
// Serial master model that drives the switch register bank's pins
module osw_host (
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // ****************************************
  // Frame transfer
  // ****************************************
  // caller picks length and content
  // Bits go out MSB first; sclk rests low outside frames.
  task automatic xfer(input logic [47:0] bits, input int n, output logic [47:0] got);
    got  = '0;
    cs_n = 1'b0;
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #3;
      got[i] = sdo;
      sclk   = 1'b1;
      #3;
      sclk = 1'b0;
    end
    #3;
    cs_n = 1'b1;
    // Released line must not look like a held bit
    sdi = ~sdi;
  endtask
endmodule

//--- tb/octal_switch_spi_register_map_test.sv
// Self-checking bench for the switch register bank
module octal_switch_spi_register_map_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock;
  logic        nrst;
  wire         sclk;
  wire         cs_n;
  wire         sdi;
  wire         sdo;
  wire         sdo_oe;
  wire  [7:0]  switch_close;
  int          err_total;
  int          num_checks;
  logic        crc_on;
  logic [47:0] got;

  osw_regs i_osw_regs (
    .clock        (clock),
    .nrst         (nrst),
    .sclk         (sclk),
    .cs_n         (cs_n),
    .sdi          (sdi),
    .sdo          (sdo),
    .sdo_oe       (sdo_oe),
    .switch_close (switch_close)
  );

  osw_host i_osw_host (
    .sclk (sclk),
    .cs_n (cs_n),
    .sdi  (sdi),
    .sdo  (sdo)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = (c << 1) ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Long gap lets the crossing and staged switch update land
  task automatic frame(input logic [47:0] bits, input int n);
    i_osw_host.xfer(bits, n, got);
    repeat (20) @(posedge clock);
    #1;
  endtask

  task automatic send(input logic [15:0] w);
    if (crc_on) begin
      frame({24'h0, w, crc8(w)}, 24);
    end else begin
      frame({32'h0, w}, 16);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send({1'b0, a, d});
  endtask

  // Answer comes back in the following word slot
  task automatic rchk(input string name, input logic [6:0] a, input logic [7:0] exp);
    send({1'b1, a, 8'h00});
    send({1'b1, 7'h01, 8'h00});
    chk(name, exp, crc_on ? got[15:8] : got[7:0]);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("switch_close", 8'h00, switch_close); // all open
    chk("sdo_oe", 8'h00, {7'h00, sdo_oe}); // released outside frames
    fork
      rchk("switch_state", 7'h01, 8'h00); // reset value
      begin
        #20;
        chk("sdo_oe", 8'h01, {7'h00, sdo_oe}); // driven in frame
      end
    join
    rchk("error_check_enable", 7'h02, 8'h06); // reset value
    rchk("error_status", 7'h03, 8'h00); // starts clear
    rchk("burst_enable", 7'h05, 8'h00); // burst off
    rchk("soft_reset_key", 7'h0B, 8'h00); // key reset value
    $display("test reset done");
  endtask

  task automatic t_switch;
    wr(7'h01, 8'hA5);
    chk("switch_close", 8'hA5, switch_close); // bit per switch
    rchk("switch_state", 7'h01, 8'hA5); // read back
    wr(7'h01, 8'h5A);
    chk("switch_close", 8'h5A, switch_close); // inverted pattern
    $display("test switch done");
  endtask

  task automatic t_count;
    frame({32'h0, 16'h0177 >> 1}, 15);
    chk("switch_close", 8'h5A, switch_close); // short frame dropped
    rchk("error_status", 7'h03, 8'h02); // count flag
    send(16'h6CA9);
    rchk("error_status", 7'h03, 8'h00); // clear, no address flag
    $display("test count done");
  endtask

  task automatic t_addr;
    wr(7'h04, 8'h55);
    rchk("error_status", 7'h03, 8'h04); // unmapped write
    send(16'h6CA9);
    wr(7'h03, 8'hFF);
    rchk("error_status", 7'h03, 8'h04); // read-only write
    send(16'h6CA9);
    wr(7'h02, 8'h02);
    rchk("error_check_enable", 7'h02, 8'h02); // address check off, count on
    wr(7'h04, 8'h55);
    rchk("error_status", 7'h03, 8'h00); // detection off
    chk("switch_close", 8'h5A, switch_close); // no side effect
    wr(7'h02, 8'h06);
    $display("test address done");
  endtask

  task automatic t_crc;
    wr(7'h02, 8'h07);
    crc_on = 1'b1;
    wr(7'h01, 8'h3C);
    chk("switch_close", 8'h3C, switch_close); // good 24-bit frame
    frame({24'h0, 16'h0181, crc8(16'h0181) ^ 8'hFF}, 24);
    chk("switch_close", 8'h3C, switch_close); // bad check byte refused
    rchk("error_status", 7'h03, 8'h01); // check flag
    send(16'h6CA9);
    rchk("error_status", 7'h03, 8'h00); // clear with check byte
    wr(7'h0B, 8'hA3);
    wr(7'h0B, 8'h05);
    crc_on = 1'b0;
    chk("switch_close", 8'h00, switch_close); // soft reset opens all
    rchk("error_check_enable", 7'h02, 8'h06); // defaults back
    $display("test crc done");
  endtask

  task automatic t_burst;
    wr(7'h05, 8'h01);
    frame({16'h0, 16'h0111, 16'h0122}, 32);
    chk("switch_close", 8'h22, switch_close); // two words one frame
    rchk("error_status", 7'h03, 8'h00); // multiple of 16
    frame({24'h0, 16'h0144, 8'h01}, 24);
    chk("switch_close", 8'h22, switch_close); // odd total dropped
    rchk("error_status", 7'h03, 8'h02); // count flag
    send(16'h6CA9);
    wr(7'h02, 8'h07);
    crc_on = 1'b1;
    frame({16'h0133, crc8(16'h0133), 16'h0166, crc8(16'h0166)}, 48);
    chk("switch_close", 8'h66, switch_close); // two checked words
    rchk("error_status", 7'h03, 8'h00); // multiple of 24
    wr(7'h02, 8'h06);
    crc_on = 1'b0;
    wr(7'h05, 8'h00);
    $display("test burst done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    nrst       = 1'b0;
    crc_on     = 1'b0;
    err_total  = 0;
    num_checks = 0;
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    t_reset();
    t_switch();
    t_count();
    t_addr();
    t_crc();
    t_burst();
    conclude();
  end

  // Whole run needs about 13 us; over seven times that means a hang
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule
